// ---- logic/reset_sequencer.sv ----
// reset sequencer: power-up, brown-out, oscillator start-up, watchdog, halt, config word
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`include "reset_seq_map.svh"

module reset_sequencer
  import reset_seq_pkg::*;
#(
  parameter int DELAY_CYCLES = `DELAY_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mclr_n,
  input wire logic brownout_n,
  input wire logic osc_ready,
  input wire logic prog_mode,
  input wire logic watchdog_rc_clk,
  input wire logic sleep_req,
  input wire logic irq_wake,
  output logic core_reset_n,
  output logic sleeping,
  output logic [1:0] osc_select
);

  seq_regs_t st_reg;
  seq_regs_t st_next;
  logic watchdog_to;
  logic mclr_ok;
  logic brownout_act;
  logic osc_ok;
  logic prog_ok;
  logic delay_en;
  logic in_reset;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_cfg;
  logic acc;
  logic wr_bad;
  logic [4:0] cause_clr;
  logic [31:0] rd_word;

  // decoded pin levels, all taken after the second sync stage
  assign mclr_ok = st_reg.pin_sync[`PIN_MCLR];
  assign brownout_act = st_reg.cfg_eff[`CFG_BROWNOUT_EN_BIT] && !st_reg.pin_sync[`PIN_BROWN];
  assign osc_ok = st_reg.pin_sync[`PIN_OSC];
  assign prog_ok = st_reg.pin_sync[`PIN_PROG];
  // brown-out enable overrides the active-low delay enable
  assign delay_en = st_reg.cfg_eff[`CFG_BROWNOUT_EN_BIT]
      || !st_reg.cfg_eff[`CFG_DELAY_EN_BIT];
  assign in_reset = (st_reg.state == seq_delay) || (st_reg.state == seq_startup);

  // apb decode; zero wait states, so pready is tied high
  assign acc = psel && penable;
  assign hit_ctrl = (paddr == `CTRL_ADDR);
  assign hit_stat = (paddr == `STATUS_ADDR);
  assign hit_cfg = (paddr == `CFG_ADDR);
  assign wr_bad = pwrite && hit_cfg && !prog_ok;
  assign pready = 1'b1;
  assign pslverr = acc && (!(hit_ctrl || hit_stat || hit_cfg) || wr_bad);

  // read mux; sampled in the setup phase so prdata is a flop in the access phase
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_cfg) begin
      rd_word[13:0] = st_reg.cfg_store;
    end else if (hit_stat) begin
      rd_word[`STAT_IN_RESET_BIT] = in_reset;
      rd_word[`STAT_SLEEPING_BIT] = (st_reg.state == seq_sleep);
      rd_word[`STAT_DELAY_BIT] = (st_reg.state == seq_delay);
      rd_word[`STAT_STARTUP_BIT] = (st_reg.state == seq_startup);
      rd_word[`STAT_PROG_BIT] = prog_ok;
      rd_word[`STAT_CAUSE_MSB:`STAT_CAUSE_LSB] = st_reg.cause;
    end
  end

  // write-one-to-clear mask for the cause flags
  always_comb begin
    cause_clr = 5'h00;
    if (acc && pwrite && hit_stat) begin
      cause_clr = pwdata[`STAT_CAUSE_MSB:`STAT_CAUSE_LSB];
    end
  end

  // whole next state: pin sync, bus side effects, then the sequencer
  always_comb begin
    st_next = st_reg;
    st_next.pin_meta = {prog_mode, osc_ready, brownout_n, mclr_n};
    st_next.pin_sync = st_reg.pin_meta;
    st_next.watchdog_clear = 1'b0;
    st_next.cause = st_reg.cause & ~cause_clr;
    if (psel && !penable && !pwrite) begin
      st_next.prdata = rd_word;
    end
    if (acc && pwrite && hit_ctrl) begin
      st_next.watchdog_clear = pwdata[`CTRL_WATCHDOG_CLEAR_BIT];
    end
    // programming can only turn blank ones into zeros, bit 7 stays one
    if (acc && pwrite && hit_cfg && prog_ok) begin
      st_next.cfg_store = st_reg.cfg_store & (pwdata[13:0] | `CFG_FIXED_ONES);
    end
    // config is sampled only while the core is held in reset
    if (in_reset) begin
      st_next.cfg_eff = st_reg.cfg_store;
    end
    // cause flags set after the clear so a same-cycle event wins
    if (brownout_act) begin
      st_next.state = seq_delay;
      st_next.delay_cnt = 24'h000000;
      st_next.cause.brownout = 1'b1;
    end else if (!mclr_ok && st_reg.state != seq_delay) begin
      // external reset skips the power-up delay
      st_next.state = seq_startup;
      st_next.cause.mclr = 1'b1;
    end else begin
      unique case (st_reg.state)
        seq_delay: begin
          if (mclr_ok && (!delay_en || st_reg.delay_cnt == 24'(DELAY_CYCLES - 1))) begin
            st_next.state = seq_startup;
          end else if (delay_en && st_reg.delay_cnt != 24'(DELAY_CYCLES - 1)) begin
            st_next.delay_cnt = st_reg.delay_cnt + 24'h000001;
          end
        end
        seq_startup: begin
          // rc mode has no crystal to wait for
          if (st_reg.cfg_eff[`CFG_OSC_MSB:`CFG_OSC_LSB] == `OSC_RC || osc_ok) begin
            st_next.state = seq_run;
          end
        end
        seq_run: begin
          if (watchdog_to) begin
            st_next.state = seq_startup;
            st_next.cause.watchdog = 1'b1;
          end else if (sleep_req) begin
            st_next.state = seq_sleep;
          end
        end
        seq_sleep: begin
          if (watchdog_to || irq_wake) begin
            st_next.state = seq_run;
            st_next.cause.wake = 1'b1;
          end
        end
      endcase
    end
  end

  // power-on: blank config, delay counter cleared, power-up cause set
  // sync flops start idle, else a false brown-out follows every reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.pin_meta <= `PIN_IDLE;
      st_reg.pin_sync <= `PIN_IDLE;
      st_reg.state <= seq_delay;
      st_reg.cfg_store <= `CFG_RESET;
      st_reg.cfg_eff <= `CFG_RESET;
      st_reg.cause.por <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // watchdog kept clear while the core is held in reset
  watchdog_timer u_watchdog (
    .pclk(pclk),
    .presetn(presetn),
    .rc_clk(watchdog_rc_clk),
    .enable(st_reg.cfg_eff[`CFG_WATCHDOG_EN_BIT]),
    .clear(st_reg.watchdog_clear || in_reset),
    .timeout(watchdog_to)
  );

  assign prdata = st_reg.prdata;
  assign core_reset_n = !in_reset;
  assign sleeping = (st_reg.state == seq_sleep);
  assign osc_select = st_reg.cfg_eff[`CFG_OSC_MSB:`CFG_OSC_LSB];

  // checks
  sequence brownout_seen_s;
    brownout_act;
  endsequence

  sequence sleep_irq_s;
    st_reg.state == seq_sleep && irq_wake && mclr_ok && !brownout_act;
  endsequence

  a_delay_full_count: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.state == seq_delay && st_next.state == seq_startup && !brownout_act && delay_en)
    |-> st_reg.delay_cnt == 24'(DELAY_CYCLES - 1)) else $error("power-up delay cut short");

  a_brownout_reset_hold: assert property (@(posedge pclk) disable iff (!presetn)
    brownout_seen_s |=> (st_reg.state == seq_delay && st_reg.delay_cnt == 24'h000000
    && !core_reset_n)) else $error("brown-out did not restart delay");

  a_startup_wait_osc: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.state == seq_startup && !osc_ok && st_reg.cfg_eff[1:0] != `OSC_RC)
    |=> !core_reset_n) else $error("released before oscillator stable");

  a_release_clean: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(core_reset_n) |-> $past(mclr_ok) && !$past(brownout_act))
    else $error("released with reset source active");

  a_sleep_wake_irq: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_irq_s |=> sleeping == 1'b0 && core_reset_n) else $error("interrupt did not wake");

  a_cfg_one_way: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.cfg_store & ~$past(st_reg.cfg_store)) == 14'h0000)
    else $error("config bit returned to blank");

  a_cfg_write_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && hit_cfg && !prog_ok) |-> pslverr ##1 $stable(st_reg.cfg_store))
    else $error("config written outside programming mode");

  a_cfg_eff_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (!in_reset && !$past(in_reset)) |-> $stable(st_reg.cfg_eff))
    else $error("config changed while running");

endmodule : reset_sequencer

// ---- logic/reset_seq_map.svh ----
// register offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RESET_SEQ_MAP_SVH
`define RESET_SEQ_MAP_SVH

// clock and timing
`define CLK_FREQ_KHZ 200000
`define DELAY_TIME_MS 72
`define DELAY_CYCLES (`DELAY_TIME_MS * `CLK_FREQ_KHZ)
`define WATCHDOG_TICKS 16'h0800

// register map (config word index kept, byte address is four times it)
`define CTRL_ADDR 16'h0000
`define STATUS_ADDR 16'h0004
`define CFG_INDEX 16'h2007
`define CFG_ADDR (`CFG_INDEX * 16'h0004)

// control register fields
`define CTRL_WATCHDOG_CLEAR_BIT 0

// status register fields
`define STAT_IN_RESET_BIT 0
`define STAT_SLEEPING_BIT 1
`define STAT_DELAY_BIT 2
`define STAT_STARTUP_BIT 3
`define STAT_PROG_BIT 4
`define STAT_CAUSE_LSB 8
`define STAT_CAUSE_MSB 12

// configuration word fields
`define CFG_RESET 14'h3fff
`define CFG_FIXED_ONES 14'h0080
`define CFG_BROWNOUT_EN_BIT 6
`define CFG_DELAY_EN_BIT 3
`define CFG_WATCHDOG_EN_BIT 2
`define CFG_OSC_MSB 1
`define CFG_OSC_LSB 0
`define CFG_CP_HI_MSB 13
`define CFG_CP_HI_LSB 8
`define CFG_CP_LO_MSB 5
`define CFG_CP_LO_LSB 4

// oscillator select codes
`define OSC_RC 2'b11
`define OSC_HS 2'b10
`define OSC_XT 2'b01
`define OSC_LP 2'b00

// synchronised pin positions
`define PIN_MCLR 0
`define PIN_BROWN 1
`define PIN_OSC 2
`define PIN_PROG 3
// sync flops start at the pins' idle levels: reset pins high, others low
`define PIN_IDLE 4'h3

`endif

// ---- logic/reset_seq_pkg.sv ----
// types shared by the reset sequencer and its watchdog
package reset_seq_pkg;

  typedef enum logic [1:0] {seq_delay, seq_startup, seq_run, seq_sleep} seq_state_t;

  // sticky reset and wake causes
  typedef struct packed {
    logic por;
    logic brownout;
    logic mclr;
    logic watchdog;
    logic wake;
  } cause_t;

  typedef struct packed {
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    seq_state_t state;
    logic [23:0] delay_cnt;
    logic [13:0] cfg_store;
    logic [13:0] cfg_eff;
    cause_t cause;
    logic [31:0] prdata;
    logic watchdog_clear;
  } seq_regs_t;

  typedef struct packed {
    logic rc_meta;
    logic rc_sync;
    logic rc_prev;
    logic [15:0] cnt;
    logic timeout;
  } watchdog_regs_t;

endpackage : reset_seq_pkg

// ---- logic/watchdog_timer.sv ----
// watchdog counting edges of its private rc oscillator
`timescale 1ns/100ps
`include "reset_seq_map.svh"

module watchdog_timer
  import reset_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rc_clk,
  input wire logic enable,
  input wire logic clear,
  output logic timeout
);

  watchdog_regs_t wd_reg;
  watchdog_regs_t wd_next;

  // rc edges counted in the bus domain; rc must run well below pclk/2
  always_comb begin
    wd_next = wd_reg;
    wd_next.rc_meta = rc_clk;
    wd_next.rc_sync = wd_reg.rc_meta;
    wd_next.rc_prev = wd_reg.rc_sync;
    wd_next.timeout = 1'b0;
    if (!enable || clear) begin
      wd_next.cnt = 16'h0000;
    end else if (wd_reg.rc_sync && !wd_reg.rc_prev) begin
      if (wd_reg.cnt == `WATCHDOG_TICKS - 16'h0001) begin
        wd_next.cnt = 16'h0000;
        wd_next.timeout = 1'b1;
      end else begin
        wd_next.cnt = wd_reg.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_reg <= '0;
    end else begin
      wd_reg <= wd_next;
    end
  end

  assign timeout = wd_reg.timeout;

  // a disabled watchdog never fires
  a_watchdog_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !enable |=> !timeout) else $error("watchdog fired while disabled");

endmodule : watchdog_timer

// ---- sim/core_side_model.sv ----
// far-side model: watchdog rc oscillator and crystal start-up
`timescale 1ns/100ps

module core_side_model (
  input wire logic pclk,
  input wire logic osc_on,
  output logic rc_clk,
  output logic osc_ready
);
  logic [2:0] div_reg = 3'h0;
  logic [3:0] warm_reg = 4'h0;

  // rc clock at pclk/8, slow enough for the two-flop sampler
  always_ff @(posedge pclk) begin
    div_reg <= div_reg + 3'h1;
  end
  assign rc_clk = div_reg[2];

  // crystal needs a few cycles after power-on before it is stable
  always_ff @(posedge pclk) begin
    if (!osc_on) warm_reg <= 4'h0;
    else if (warm_reg != 4'hf) warm_reg <= warm_reg + 4'h1;
  end
  assign osc_ready = (warm_reg == 4'hf);
endmodule : core_side_model

// ---- sim/test_reset_sequencer.sv ----
// testbench of the reset sequencer over apb and its pins
`timescale 1ns/100ps
`include "reset_seq_map.svh"

module test_reset_sequencer;
  import reset_seq_pkg::*;
  localparam int DLY = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, core_reset_n, sleeping, rc_clk, osc_ready;
  logic [1:0] osc_select;
  logic mclr_n = 1'b1;
  logic brownout_n = 1'b1;
  logic prog_mode = 1'b0;
  logic sleep_req = 1'b0;
  logic irq_wake = 1'b0;
  logic osc_on = 1'b1;
  logic [31:0] r;
  logic e;
  int n;
  int mismatches = 0;
  int checked = 0;

  reset_sequencer #(.DELAY_CYCLES(DLY)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mclr_n(mclr_n),
    .brownout_n(brownout_n), .osc_ready(osc_ready), .prog_mode(prog_mode),
    .watchdog_rc_clk(rc_clk), .sleep_req(sleep_req), .irq_wake(irq_wake),
    .core_reset_n(core_reset_n), .sleeping(sleeping), .osc_select(osc_select));

  core_side_model far (.pclk(pclk), .osc_on(osc_on), .rc_clk(rc_clk),
    .osc_ready(osc_ready));

  // 200 mhz clock
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  task complete_run;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk

  // one apb transfer; data and error taken at the pready edge
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) mismatches++;
    if (pready !== 1'b1) complete_run();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // bounded wait for core reset to reach a level, sampled mid-cycle; n counts every cycle waited
  task wait_rst(input logic lvl, input int lim);
    n = 1;
    @(negedge pclk);
    while (core_reset_n !== lvl && n < lim) begin
      @(negedge pclk);
      n++;
    end
    if (core_reset_n !== lvl) mismatches++;
    if (core_reset_n !== lvl) complete_run();
  endtask : wait_rst

  task cyc(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask : cyc

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    chk(core_reset_n, 32'h0);
    wait_rst(1'b1, 200);
    chk(32'(n >= DLY), 32'h1);
    chk(osc_select, 32'h3);
    apb(1'b0, `CFG_ADDR, 32'h0);
    chk(r, 32'h3fff);
    apb(1'b0, `STATUS_ADDR, 32'h0);
    chk(r, 32'h1000);
    apb(1'b1, `STATUS_ADDR, 32'h1f00);
    apb(1'b1, `CFG_ADDR, 32'h0);
    chk(e, 32'h1);
    apb(1'b0, `CFG_ADDR, 32'h0);
    chk(r, 32'h3fff);
    apb(1'b0, 16'h0100, 32'h0);
    chk({r[30:0], e}, 32'h1);
    // program brown-out on, delay bit off, watchdog on, xt oscillator
    @(posedge pclk) prog_mode <= 1'b1;
    cyc(4);
    apb(1'b1, `CFG_ADDR, 32'h3ffd);
    chk(e, 32'h0);
    @(posedge pclk) prog_mode <= 1'b0;
    apb(1'b0, `CFG_ADDR, 32'h0);
    chk(r, 32'h3ffd);
    chk(osc_select, 32'h3);
    // external reset with the crystal stopped
    @(posedge pclk) osc_on <= 1'b0;
    @(posedge pclk) mclr_n <= 1'b0;
    cyc(6);
    chk({core_reset_n, osc_select}, 32'h1);
    @(posedge pclk) mclr_n <= 1'b1;
    cyc(40);
    chk(core_reset_n, 32'h0);
    @(posedge pclk) osc_on <= 1'b1;
    wait_rst(1'b1, 100);
    apb(1'b0, `STATUS_ADDR, 32'h0);
    chk(r, 32'h0400);
    // halt left by interrupt, then by watchdog
    @(posedge pclk) sleep_req <= 1'b1;
    @(posedge pclk) sleep_req <= 1'b0;
    cyc(3);
    chk(sleeping, 32'h1);
    @(posedge pclk) irq_wake <= 1'b1;
    @(posedge pclk) irq_wake <= 1'b0;
    cyc(3);
    chk(sleeping, 32'h0);
    apb(1'b1, `STATUS_ADDR, 32'h1f00);
    @(posedge pclk) sleep_req <= 1'b1;
    @(posedge pclk) sleep_req <= 1'b0;
    // let the halt state settle before polling it
    cyc(1);
    n = 0;
    while (sleeping !== 1'b0 && n < 20000) begin
      @(negedge pclk);
      n++;
    end
    if (sleeping !== 1'b0) mismatches++;
    if (sleeping !== 1'b0) complete_run();
    chk({core_reset_n, 31'(n >= 16000 && n < 20000)}, 32'h80000001);
    apb(1'b0, `STATUS_ADDR, 32'h0);
    chk(r, 32'h0100);
    apb(1'b1, `STATUS_ADDR, 32'h1f00);
    // clearing the count keeps the core running past one period
    cyc(12000);
    apb(1'b1, `CTRL_ADDR, 32'h1);
    cyc(12000);
    chk(core_reset_n, 32'h1);
    wait_rst(1'b0, 20000);
    wait_rst(1'b1, 100);
    apb(1'b0, `STATUS_ADDR, 32'h0);
    chk(r, 32'h0200);
    apb(1'b1, `STATUS_ADDR, 32'h1f00);
    // brown-out re-runs the full delay although the delay bit is off
    @(posedge pclk) brownout_n <= 1'b0;
    cyc(6);
    chk(core_reset_n, 32'h0);
    @(posedge pclk) brownout_n <= 1'b1;
    wait_rst(1'b1, 200);
    chk(32'(n >= DLY), 32'h1);
    apb(1'b0, `STATUS_ADDR, 32'h0);
    chk(r, 32'h0800);
    apb(1'b1, `STATUS_ADDR, 32'h1f00);
    // watchdog programmed off: no timeout over more than one period
    @(posedge pclk) prog_mode <= 1'b1;
    cyc(4);
    apb(1'b1, `CFG_ADDR, 32'h3ff9);
    chk(e, 32'h0);
    @(posedge pclk) prog_mode <= 1'b0;
    @(posedge pclk) mclr_n <= 1'b0;
    cyc(6);
    @(posedge pclk) mclr_n <= 1'b1;
    wait_rst(1'b1, 100);
    cyc(17000);
    chk(core_reset_n, 32'h1);
    apb(1'b0, `STATUS_ADDR, 32'h0);
    chk(r, 32'h0400);
    complete_run();
  end
endmodule : test_reset_sequencer
